// ---- hw/iprr_resolver.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - a routine in service is pre-empted only by a strictly higher level request
// - a routine at the highest level is pre-empted only by the nmi; an nmi routine is never pre-empted
// - among simultaneous requests the highest level goes to the cpu first
// - within one level a fixed polling order picks the winner
// - polling order: nmi first, then positions 1 to 14, 14 last
module iprr_resolver (
    input  wire logic                                   clk_in,
    input  wire logic                                   arst_n_in,
    input  wire logic [iprr_pkg::NUM_SRC-1:0]           req_in,
    input  wire logic [iprr_pkg::NUM_SRC*iprr_pkg::LVL_W-1:0] lvl_in,
    input  wire logic                                   ack_in,
    input  wire logic                                   ret_in,
    output logic                                        irq_out,
    output logic [iprr_pkg::SRC_W-1:0]                  src_out,
    output logic [iprr_pkg::ACT_W-1:0]                  act_lvl_out,
    output logic                                        busy_out
);
    import iprr_pkg::*;

    logic [ACT_W-1:0]         stack [DEPTH];
    logic [PTR_W-1:0]         ptr;
    logic [ACT_W-1:0]         cur;
    logic                     cand_v;
    logic [SRC_W-1:0]         cand_src;
    logic [ACT_W-1:0]         cand_lvl;
    logic                     next_irq;
    logic [ACT_W-1:0]         req_code [NUM_SRC];

    // per-source code: nmi above every maskable level, maskable levels offset by one
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_code
            if (g == NMI_IDX) begin : g_nmi
                assign req_code[g] = ACT_NMI;
            end else begin : g_mask
                assign req_code[g] = {1'b0, lvl_in[g*LVL_W +: LVL_W]} + 3'h1;
            end
        end
    endgenerate

    // current level in service, idle when the stack is empty
    // the pointer names the next free entry, so the top of stack sits one below it
    assign cur = (ptr == PTR_RST) ? ACT_IDLE : stack[ptr - 3'h1];

    // highest code wins, ties go to the lowest poll index
    always_comb begin
        cand_v   = 1'b0;
        cand_src = SRC_RST;
        cand_lvl = ACT_IDLE;
        for (int i = LAST_IDX; i >= NMI_IDX; i--) begin
            if (req_in[i] && (!cand_v || req_code[i] >= cand_lvl)) begin
                cand_v   = 1'b1;
                cand_src = SRC_W'(i);
                cand_lvl = req_code[i];
            end
        end
    end

    // the acknowledge cycle offers nothing, so one request is never taken twice
    // strictly higher only; nmi in service admits nothing
    assign next_irq = cand_v && (cand_lvl > cur) && (cur != ACT_NMI) && !ack_in;

    // request to the cpu, registered
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_out <= 1'b0;
            src_out <= SRC_RST;
        end else begin
            irq_out <= next_irq;
            src_out <= next_irq ? cand_src : src_out;
        end
    end

    // level stack: push on acknowledge, pop on return
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ptr <= PTR_RST;
            for (int k = 0; k < DEPTH; k++) begin
                stack[k] <= ACT_IDLE;
            end
        end else if (ack_in && irq_out && ptr != PTR_W'(DEPTH)) begin
            stack[ptr] <= req_code[src_out];
            ptr        <= ptr + 3'h1;
        end else if (ret_in && ptr != PTR_RST) begin
            ptr <= ptr - 3'h1;
        end
    end

    // visible state
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            act_lvl_out <= ACT_IDLE;
            busy_out    <= 1'b0;
        end else begin
            act_lvl_out <= cur;
            busy_out    <= (ptr != PTR_RST);
        end
    end

    // refused requests never reach the cpu: level not above the one in service
    property p_no_low_preempt;
        @(posedge clk_in) disable iff (!arst_n_in)
        (cand_v && cand_lvl <= cur) |=> !irq_out;
    endproperty
    a_no_low_preempt: assert property (p_no_low_preempt)
        else $error("pre-empt not higher");

    // the acknowledge cycle offers nothing, so a taken offer is withdrawn in the next cycle
    property p_ack_drop;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ack_in && irq_out) |=> !irq_out;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("offer stood after acknowledge");

    // an nmi routine in service shuts out every request
    property p_nmi_locks;
        @(posedge clk_in) disable iff (!arst_n_in)
        (cur == ACT_NMI) |=> !irq_out;
    endproperty
    a_nmi_locks: assert property (p_nmi_locks)
        else $error("nmi routine pre-empted");

    // a routine at the top maskable level yields to no maskable request
    property p_top_locks;
        @(posedge clk_in) disable iff (!arst_n_in)
        (cur == ({1'b0, LVL_TOP} + 3'h1) && !req_in[NMI_IDX]) |=> !irq_out;
    endproperty
    a_top_locks: assert property (p_top_locks)
        else $error("top level routine pre-empted");

    // the nmi wins in every cycle without acknowledge while it is not already in service
    property p_nmi_first;
        @(posedge clk_in) disable iff (!arst_n_in)
        (req_in[NMI_IDX] && cur != ACT_NMI && !ack_in) |=>
            (irq_out && src_out == SRC_W'(NMI_IDX));
    endproperty
    a_nmi_first: assert property (p_nmi_first)
        else $error("nmi not chosen first");

    // no request pending, no offer
    property p_idle_quiet;
        @(posedge clk_in) disable iff (!arst_n_in)
        (req_in == '0) |=> !irq_out;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("offer without request");

    // the registered offer carries the winner of the cycle before
    property p_offer_src;
        @(posedge clk_in) disable iff (!arst_n_in)
        next_irq |=> (irq_out && src_out == $past(cand_src));
    endproperty
    a_offer_src: assert property (p_offer_src)
        else $error("offered source is not the winner");

    // each pending source against the winner: none higher, none polled earlier at equal level
    genvar h;
    generate
        for (h = 0; h < NUM_SRC; h++) begin : g_chk
            property p_top_wins;
                @(posedge clk_in) disable iff (!arst_n_in)
                (next_irq && req_in[h]) |-> req_code[h] <= cand_lvl;
            endproperty
            a_top_wins: assert property (p_top_wins)
                else $error("higher level passed over");

            property p_tie_poll;
                @(posedge clk_in) disable iff (!arst_n_in)
                (next_irq && req_in[h] && req_code[h] == cand_lvl) |-> cand_src <= SRC_W'(h);
            endproperty
            a_tie_poll: assert property (p_tie_poll)
                else $error("poll order broken");
        end
    endgenerate

    // an acknowledge pushes the level of the offered source
    property p_push;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ack_in && irq_out && ptr != PTR_W'(DEPTH)) |=>
            (ptr == $past(ptr) + 3'h1) && (cur == $past(req_code[src_out]));
    endproperty
    a_push: assert property (p_push)
        else $error("acknowledge did not record level");

    // a full stack ignores further acknowledges
    property p_full_hold;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ack_in && irq_out && ptr == PTR_W'(DEPTH)) |=> ptr == $past(ptr);
    endproperty
    a_full_hold: assert property (p_full_hold)
        else $error("push beyond full stack");

    // a return drops exactly one level
    property p_pop;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ret_in && !(ack_in && irq_out) && ptr != PTR_RST) |=> ptr == $past(ptr) - 3'h1;
    endproperty
    a_pop: assert property (p_pop)
        else $error("return did not restore level");

    // a return with nothing in service is ignored
    property p_empty_ret;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ret_in && !(ack_in && irq_out) && ptr == PTR_RST) |=> ptr == PTR_RST;
    endproperty
    a_empty_ret: assert property (p_empty_ret)
        else $error("return on empty stack moved pointer");

    // the pointer never leaves the stack
    property p_ptr_range;
        @(posedge clk_in) disable iff (!arst_n_in)
        ptr <= PTR_W'(DEPTH);
    endproperty
    a_ptr_range: assert property (p_ptr_range)
        else $error("stack pointer out of range");

    // visible level and busy flag follow the stack one cycle later
    property p_act_follow;
        @(posedge clk_in) disable iff (!arst_n_in)
        1'b1 |=> (act_lvl_out == $past(cur)) && (busy_out == ($past(ptr) != PTR_RST));
    endproperty
    a_act_follow: assert property (p_act_follow)
        else $error("visible level lags wrongly");

    // the last return brings the block back to idle
    property p_ret_idle;
        @(posedge clk_in) disable iff (!arst_n_in)
        (ret_in && !(ack_in && irq_out) && ptr == 3'h1) |=>
            ##1 (!busy_out && act_lvl_out == ACT_IDLE);
    endproperty
    a_ret_idle: assert property (p_ret_idle)
        else $error("last return did not reach idle");

    // main scenarios: nesting, nmi service, last return, sources 1 and 2 pending together, pre-emption taken
    c_nest:    cover property (@(posedge clk_in) disable iff (!arst_n_in) ptr == 3'h2);
    c_nmi:     cover property (@(posedge clk_in) disable iff (!arst_n_in) cur == ACT_NMI);
    c_ret:     cover property (@(posedge clk_in) disable iff (!arst_n_in) ret_in && ptr == 3'h1);
    c_tie:     cover property (@(posedge clk_in) disable iff (!arst_n_in)
                   next_irq && req_in[1] && req_in[2]);
    c_preempt: cover property (@(posedge clk_in) disable iff (!arst_n_in)
                   ack_in && irq_out && ptr != PTR_RST);
endmodule : iprr_resolver
`default_nettype wire

// ---- shared/iprr_pkg.sv ----
package iprr_pkg;
    // request sources: index 0 is the non-maskable request, 1..14 the polled sources
    localparam int          NUM_SRC     = 15;
    localparam int          SRC_W       = 4;
    localparam int          NMI_IDX     = 0;
    localparam int          LAST_IDX    = 14;
    // priority levels: 0 lowest .. 3 highest, nmi sits above all of them
    localparam int          LVL_W       = 2;
    localparam logic [1:0]  LVL_TOP     = 2'h3;
    // level stack, one entry per nesting depth (four levels plus nmi)
    localparam int          DEPTH       = 5;
    localparam int          PTR_W       = 3;
    localparam logic [2:0]  PTR_RST     = 3'h0;
    localparam logic [3:0]  SRC_RST     = 4'h0;
    // active level code: 0 idle, maskable level plus one (1 to 4), 7 marks "nmi in service"
    localparam int          ACT_W       = 3;
    localparam logic [2:0]  ACT_IDLE    = 3'h0;
    localparam logic [2:0]  ACT_NMI     = 3'h7;
endpackage : iprr_pkg

// ---- tb/iprr_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module iprr_cpu_model (
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    input  wire logic en_in,
    input  wire logic irq_in,
    output logic      ack_out
);
    // takes an offered request a cycle later, one pulse per offer
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) ack_out <= 1'b0;
        else ack_out <= en_in & irq_in & ~ack_out;
    end
endmodule : iprr_cpu_model
`default_nettype wire

// ---- tb/tb_iprr_resolver.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_iprr_resolver;
    import iprr_pkg::*;
    logic clk_in = 0, arst_n_in = 0, ack, ret = 0, en = 0, irq, busy;
    logic [14:0] req = 15'h0;
    logic [29:0] lvl = 30'h0;
    logic [3:0]  src;
    logic [2:0]  act;
    int          err_count = 0, cmp_count = 0, cyc = 0;
    iprr_resolver uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(req), .lvl_in(lvl),
        .ack_in(ack), .ret_in(ret), .irq_out(irq), .src_out(src), .act_lvl_out(act),
        .busy_out(busy));
    iprr_cpu_model cpu (.clk_in(clk_in), .arst_n_in(arst_n_in), .en_in(en), .irq_in(irq),
        .ack_out(ack));
    // clock and cycle ceiling
    initial forever #2 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_count++;
            conclude();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : step
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic take();
        en = 1;
        step(3);
        en = 0;
    endtask : take
    // same level: fixed polling order, nmi ahead of all
    task automatic t_tie();
        lvl = {15{2'h2}};
        req = 15'h7fff;
        step(2);
        chk({irq, src}, 8'h10);
        for (int k = 1; k <= 14; k++) begin
            req = 15'h7fff << k;
            step(2);
            chk({irq, src}, 8'h10 | 8'(k));
        end
    endtask : t_tie
    // mixed levels: highest level beats polling order
    task automatic t_lvl();
        lvl = {2'h3, {13{2'h0}}, 2'h0};
        req = 15'h4002;
        step(2);
        chk({irq, src}, 8'h1e);
    endtask : t_lvl
    // nesting, refusal of equal and lower levels, restore on return
    task automatic t_nest();
        lvl = 30'hc14;
        req = 15'h0004;
        step(2);
        take();
        chk({act, irq}, 8'h04);
        req = 15'h0022;
        step(3);
        chk({act, irq, src}, 8'h55);
        take();
        step(2);
        chk({busy, act, irq}, 8'h18);
        req = 15'h0002;
        ret = 1;
        step(1);
        ret = 0;
        step(2);
        chk({act, irq}, 8'h04);
        ret = 1;
        step(1);
        ret = 0;
        step(3);
        chk({busy, act, irq, src}, 16'h0011);
        req = 15'h0;
    endtask : t_nest
    // nmi in service shuts out even a top-level request until it returns
    task automatic t_nmi();
        req = 15'h0001;
        step(2);
        chk({irq, src}, 8'h10);
        take();
        req = 15'h0020;
        step(2);
        chk({busy, act, irq}, 8'h1e);
        ret = 1;
        step(1);
        ret = 0;
        step(2);
        chk({busy, act, irq, src}, 16'h0015);
        req = 15'h0;
    endtask : t_nmi
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    initial begin
        step(16);
        arst_n_in = 1;
        step(1);
        t_tie();
        t_lvl();
        t_nest();
        t_nmi();
        conclude();
    end
endmodule : tb_iprr_resolver
`default_nettype wire
